// File: hdl/usart_pkg.sv
package usart_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_STATUS_A = 8'h04;
    localparam logic [7:0] OFF_CONTROL_B = 8'h08;
    localparam logic [7:0] OFF_CONTROL_C = 8'h0c;
    localparam logic [7:0] OFF_BAUD = 8'h10;

    // status_reg_a fields
    localparam int STA_RX_COMPLETE = 7;
    localparam int STA_TX_COMPLETE = 6;
    localparam int STA_TX_EMPTY = 5;
    localparam int STA_DOUBLE_SPEED = 1;

    // control_reg_b fields
    localparam int CTB_TX_COMPLETE_IE = 6;
    localparam int CTB_TX_EMPTY_IE = 5;
    localparam int CTB_RX_ENABLE = 4;
    localparam int CTB_TX_ENABLE = 3;
    localparam int CTB_SIZE2 = 2;
    localparam int CTB_RX_NINTH = 1;
    localparam int CTB_TX_NINTH = 0;

    // control_reg_c fields
    localparam int CTC_CLOCK_MASTER = 7;
    localparam int CTC_SYNC_MODE = 6;
    localparam int CTC_PARITY_EN = 5;
    localparam int CTC_PARITY_ODD = 4;
    localparam int CTC_TWO_STOP = 3;
    localparam int CTC_SIZE_HI = 2;
    localparam int CTC_SIZE_LO = 1;

    // Reset values
    localparam logic [7:0] RST_STATUS_A = 8'h00;
    localparam logic [7:0] RST_CONTROL_B = 8'h00;
    localparam logic [7:0] RST_CONTROL_C = 8'h06;
    localparam logic [11:0] RST_BAUD = 12'h000;

    // Character size code for nine data bits
    localparam logic [2:0] SIZE_NINE = 3'h7;
    localparam logic [3:0] NINE_BITS = 4'h9;
    localparam logic [3:0] BASE_BITS = 4'h5;

    // Oversampling per bit, normal and double speed
    localparam logic [3:0] OS_NORMAL = 4'hf;
    localparam logic [3:0] OS_DOUBLE = 4'h7;

    localparam int RX_DEPTH = 2;

    typedef struct packed {
        logic [3:0] nbits;
        logic par_en;
        logic par_odd;
        logic two_stop;
    } frame_cfg_s;

endpackage : usart_pkg

// File: hdl/usart_tx_rx_datapath.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module usart_tx_rx_datapath (
    input wire logic pclk, // APB clock
    input wire logic presetn, // Async reset, active low
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic global_irq_en, // Global interrupt enable
    input wire logic tx_complete_ack, // Transmit-complete interrupt serviced
    output logic tx_empty_irq, // Buffer-empty interrupt request
    output logic tx_complete_irq, // Transmit-complete interrupt request
    output logic serial_out_pin, // Serial output level
    output logic serial_out_oe, // Serial output driven
    input wire logic serial_in_pin, // Serial input pin
    output logic rx_pin_owned, // Receiver owns the input pin
    input wire logic sync_clock_in, // Sync clock pin input
    output logic sync_clock_out, // Sync clock pin output
    output logic sync_clock_oe // Sync clock pin driven
);

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } rx_state_e;

    logic [7:0] status_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] ctrl_c_reg;
    logic [11:0] baud_reg;
    logic [8:0] tx_buf_reg;
    logic tx_full_reg;
    logic tx_complete_reg;
    tx_state_e tx_state_reg;
    logic [12:0] tx_shift_reg;
    logic [3:0] tx_cnt_reg;
    logic [3:0] tx_os_reg;
    logic [11:0] baud_cnt_reg;
    logic tick;
    logic xck_reg;
    logic xck_s1_reg, xck_s2_reg, xck_prev_reg;
    logic rxd_s1_reg, rxd_s2_reg;
    rx_state_e rx_state_reg;
    logic [3:0] rx_os_reg;
    logic [3:0] rx_idx_reg;
    logic [8:0] rx_shift_reg;
    logic [8:0] rx_fifo [usart_pkg::RX_DEPTH];
    logic rx_wr_reg, rx_rd_reg;
    logic [1:0] rx_count_reg;
    logic [31:0] prdata_reg;

    usart_pkg::frame_cfg_s cfg;
    logic sync_mode, clk_master, tx_en, rx_en;
    logic xck_level, tx_edge, rx_edge;
    logic [3:0] os_len;
    logic tx_bit_end, tx_load, tx_finish;
    logic rx_sample, rx_push, rx_pop;
    logic wr_acc, rd_setup, rd_acc, mapped;
    logic wr_data, wr_status, wr_ctrl_b, wr_ctrl_c, wr_baud;
    logic [8:0] rx_head;

    assign sync_mode = ctrl_c_reg[usart_pkg::CTC_SYNC_MODE];
    assign clk_master = ctrl_c_reg[usart_pkg::CTC_CLOCK_MASTER];
    assign tx_en = ctrl_b_reg[usart_pkg::CTB_TX_ENABLE];
    assign rx_en = ctrl_b_reg[usart_pkg::CTB_RX_ENABLE];

    always_comb
    begin
        if ({ctrl_b_reg[usart_pkg::CTB_SIZE2], ctrl_c_reg[usart_pkg::CTC_SIZE_HI:
                usart_pkg::CTC_SIZE_LO]} == usart_pkg::SIZE_NINE)
            cfg.nbits = usart_pkg::NINE_BITS;
        else
            cfg.nbits = usart_pkg::BASE_BITS + {2'h0, ctrl_c_reg[2:1]};
        cfg.par_en = ctrl_c_reg[usart_pkg::CTC_PARITY_EN];
        cfg.par_odd = ctrl_c_reg[usart_pkg::CTC_PARITY_ODD];
        cfg.two_stop = ctrl_c_reg[usart_pkg::CTC_TWO_STOP];
    end

    // Start, data LSB first, parity, then stops; unused bits left high
    function automatic logic [12:0] build_frame(logic [8:0] d, usart_pkg::frame_cfg_s c);
        logic [12:0] f;
        logic p;
        f = '1;
        f[0] = 1'b0;
        p = c.par_odd;
        for (int i = 0; i < 9; i++)
        begin
            if (i < int'(c.nbits))
            begin
                f[i + 1] = d[i];
                p = p ^ d[i];
            end
        end
        if (c.par_en)
            f[c.nbits + 4'h1] = p;
        return f;
    endfunction : build_frame

    // APB decode, zero wait states
    assign pready = 1'b1;
    assign mapped = (paddr == usart_pkg::OFF_DATA) || (paddr == usart_pkg::OFF_STATUS_A)
        || (paddr == usart_pkg::OFF_CONTROL_B) || (paddr == usart_pkg::OFF_CONTROL_C)
        || (paddr == usart_pkg::OFF_BAUD);
    assign pslverr = psel && penable && !mapped;
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign wr_data = wr_acc && (paddr == usart_pkg::OFF_DATA);
    assign wr_status = wr_acc && (paddr == usart_pkg::OFF_STATUS_A);
    assign wr_ctrl_b = wr_acc && (paddr == usart_pkg::OFF_CONTROL_B);
    assign wr_ctrl_c = wr_acc && (paddr == usart_pkg::OFF_CONTROL_C);
    assign wr_baud = wr_acc && (paddr == usart_pkg::OFF_BAUD);
    assign rx_pop = rd_acc && (paddr == usart_pkg::OFF_DATA) && (rx_count_reg != 2'h0);
    assign prdata = prdata_reg;
    assign rx_head = rx_fifo[rx_rd_reg];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (ce && rd_setup)
        begin
            unique case (paddr)
                usart_pkg::OFF_DATA: prdata_reg <= {24'h0, rx_head[7:0]};
                usart_pkg::OFF_STATUS_A: prdata_reg <= {24'h0,
                    rx_count_reg != 2'h0, tx_complete_reg, !tx_full_reg,
                    3'h0, status_reg[usart_pkg::STA_DOUBLE_SPEED], 1'b0};
                usart_pkg::OFF_CONTROL_B: prdata_reg <= {24'h0, ctrl_b_reg[7:2],
                    rx_head[8], ctrl_b_reg[0]};
                usart_pkg::OFF_CONTROL_C: prdata_reg <= {24'h0, ctrl_c_reg};
                usart_pkg::OFF_BAUD: prdata_reg <= {20'h0, baud_reg};
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers; flag bits of status are not stored here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= usart_pkg::RST_STATUS_A;
            ctrl_b_reg <= usart_pkg::RST_CONTROL_B;
            ctrl_c_reg <= usart_pkg::RST_CONTROL_C;
            baud_reg <= usart_pkg::RST_BAUD;
        end
        else if (ce)
        begin
            if (wr_status)
                status_reg <= {6'h0, pwdata[usart_pkg::STA_DOUBLE_SPEED], 1'b0};
            if (wr_ctrl_b)
                ctrl_b_reg <= {pwdata[7:2], 1'b0, pwdata[0]};
            if (wr_ctrl_c)
                ctrl_c_reg <= pwdata[7:0];
            if (wr_baud)
                baud_reg <= pwdata[11:0];
        end
    end

    // Baud divider: one tick every baud_reg+1 clocks
    assign tick = (baud_cnt_reg == 12'h000);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            baud_cnt_reg <= 12'h000;
        else if (ce)
            baud_cnt_reg <= tick ? baud_reg : baud_cnt_reg - 12'h001;
    end

    // Sync clock: master toggles per tick, slave input double-synchronised
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            xck_reg <= 1'b0;
            xck_s1_reg <= 1'b0;
            xck_s2_reg <= 1'b0;
            xck_prev_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (sync_mode && clk_master && tick)
                xck_reg <= !xck_reg;
            xck_s1_reg <= sync_clock_in;
            xck_s2_reg <= xck_s1_reg;
            xck_prev_reg <= xck_level;
        end
    end

    assign xck_level = clk_master ? xck_reg : xck_s2_reg;
    assign tx_edge = sync_mode && xck_level && !xck_prev_reg;
    assign rx_edge = sync_mode && !xck_level && xck_prev_reg;
    assign sync_clock_out = xck_reg;
    assign sync_clock_oe = sync_mode && clk_master && (tx_en || rx_en);
    assign os_len = status_reg[usart_pkg::STA_DOUBLE_SPEED] ? usart_pkg::OS_DOUBLE
        : usart_pkg::OS_NORMAL;

    // Transmitter
    assign tx_bit_end = (tx_state_reg == TX_SHIFT)
        && (sync_mode ? tx_edge : (tick && tx_os_reg == os_len));
    assign tx_finish = tx_bit_end && (tx_cnt_reg == 4'h1);
    assign tx_load = tx_full_reg && tx_en
        && ((tx_state_reg == TX_IDLE) || tx_finish);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_buf_reg <= 9'h000;
            tx_full_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_data)
                tx_buf_reg <= {ctrl_b_reg[usart_pkg::CTB_TX_NINTH], pwdata[7:0]};
            tx_full_reg <= wr_data || (tx_full_reg && !tx_load);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= '1;
            tx_cnt_reg <= 4'h0;
            tx_os_reg <= 4'h0;
        end
        else if (ce)
        begin
            if (tx_load)
            begin
                tx_state_reg <= TX_SHIFT;
                tx_shift_reg <= build_frame(tx_buf_reg, cfg);
                tx_cnt_reg <= 4'h2 + cfg.nbits + {3'h0, cfg.par_en}
                    + {3'h0, cfg.two_stop};
                tx_os_reg <= 4'h0;
            end
            else
            begin
                if (tick && tx_state_reg == TX_SHIFT)
                    tx_os_reg <= (tx_os_reg == os_len) ? 4'h0 : tx_os_reg + 4'h1;
                if (tx_bit_end)
                begin
                    tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
                    tx_cnt_reg <= tx_cnt_reg - 4'h1;
                end
                if (tx_finish)
                    tx_state_reg <= TX_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_complete_reg <= 1'b0;
        else if (ce)
        begin
            if (tx_finish && !tx_load)
                tx_complete_reg <= 1'b1;
            else if (tx_complete_ack
                || (wr_status && pwdata[usart_pkg::STA_TX_COMPLETE]))
                tx_complete_reg <= 1'b0;
        end
    end

    // Pin stays owned until shifter and buffer drain
    assign serial_out_oe = tx_en || tx_full_reg || (tx_state_reg == TX_SHIFT);
    assign serial_out_pin = (tx_state_reg == TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
    assign tx_empty_irq = global_irq_en && ctrl_b_reg[usart_pkg::CTB_TX_EMPTY_IE]
        && !tx_full_reg;
    assign tx_complete_irq = global_irq_en && ctrl_b_reg[usart_pkg::CTB_TX_COMPLETE_IE]
        && tx_complete_reg;

    // Receiver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxd_s1_reg <= 1'b1;
            rxd_s2_reg <= 1'b1;
        end
        else if (ce)
        begin
            rxd_s1_reg <= serial_in_pin;
            rxd_s2_reg <= rxd_s1_reg;
        end
    end

    assign rx_pin_owned = rx_en;
    assign rx_sample = (rx_state_reg == RX_DATA)
        && (sync_mode ? rx_edge : (tick && rx_os_reg == os_len));
    assign rx_push = rx_sample && (rx_idx_reg == cfg.nbits + {3'h0, cfg.par_en});

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state_reg <= RX_IDLE;
            rx_os_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
        end
        else if (ce)
        begin
            if (!rx_en)
                rx_state_reg <= RX_IDLE;
            else
            begin
                if (tick)
                    rx_os_reg <= (rx_os_reg == os_len) ? 4'h0 : rx_os_reg + 4'h1;
                unique case (rx_state_reg)
                    RX_IDLE:
                    begin
                        rx_idx_reg <= 4'h0;
                        rx_shift_reg <= 9'h000;
                        rx_os_reg <= 4'h0;
                        if (sync_mode && rx_edge && !rxd_s2_reg)
                            rx_state_reg <= RX_DATA;
                        else if (!sync_mode && !rxd_s2_reg)
                            rx_state_reg <= RX_START;
                    end
                    RX_START:
                    begin
                        // Half a bit later the start bit must still be low
                        if (tick && rx_os_reg == (os_len >> 1))
                        begin
                            rx_os_reg <= 4'h0;
                            rx_state_reg <= rxd_s2_reg ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA:
                    begin
                        if (rx_sample)
                        begin
                            if (rx_idx_reg < cfg.nbits)
                                rx_shift_reg[rx_idx_reg] <= rxd_s2_reg;
                            rx_idx_reg <= rx_idx_reg + 4'h1;
                            if (rx_push)
                                rx_state_reg <= RX_IDLE;
                        end
                    end
                    default: rx_state_reg <= RX_IDLE;
                endcase
            end
        end
    end

    // Two-entry receive buffer; a push into a full buffer is dropped
    always_ff @(posedge pclk)
    begin
        if (ce && rx_en && rx_push && rx_count_reg != 2'(usart_pkg::RX_DEPTH))
            rx_fifo[rx_wr_reg] <= rx_shift_reg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_wr_reg <= 1'b0;
            rx_rd_reg <= 1'b0;
            rx_count_reg <= 2'h0;
        end
        else if (ce)
        begin
            if (!rx_en)
            begin
                rx_wr_reg <= 1'b0;
                rx_rd_reg <= 1'b0;
                rx_count_reg <= 2'h0;
            end
            else
            begin
                if (rx_push && rx_count_reg != 2'(usart_pkg::RX_DEPTH))
                    rx_wr_reg <= !rx_wr_reg;
                if (rx_pop)
                    rx_rd_reg <= !rx_rd_reg;
                if ((rx_push && rx_count_reg != 2'(usart_pkg::RX_DEPTH)) && !rx_pop)
                    rx_count_reg <= rx_count_reg + 2'h1;
                else if (rx_pop && !(rx_push && rx_count_reg != 2'(usart_pkg::RX_DEPTH)))
                    rx_count_reg <= rx_count_reg - 2'h1;
            end
        end
    end

endmodule : usart_tx_rx_datapath

// File: test/usart_chk_sva.sv
`timescale 1ns/1ps
module usart_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pslverr, // APB error
    input wire logic global_irq_en, // Global irq enable
    input wire logic tx_empty_irq, // Buffer-empty request
    input wire logic tx_complete_irq, // Complete request
    input wire logic serial_out_pin, // Serial output
    input wire logic serial_out_oe, // Serial output driven
    input wire logic rx_pin_owned // Receiver owns input
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic ctl_wr;
    logic mapped;
    assign acc = psel && penable;
    assign ctl_wr = acc && pwrite && paddr == usart_pkg::OFF_CONTROL_B;
    assign mapped = paddr inside {usart_pkg::OFF_DATA, usart_pkg::OFF_STATUS_A,
        usart_pkg::OFF_CONTROL_B, usart_pkg::OFF_CONTROL_C, usart_pkg::OFF_BAUD};
    AST_TX_OWN: assert property (ctl_wr && pwdata[3] |=> serial_out_oe)
        else $error("tx pin not taken");
    AST_RX_OWN: assert property (ctl_wr |=> rx_pin_owned == $past(pwdata[4]))
        else $error("rx pin ownership wrong");
    AST_WR_CLEARS: assert property (acc && pwrite && paddr == usart_pkg::OFF_DATA |=> !tx_empty_irq)
        else $error("empty request after data write");
    AST_GLOBAL: assert property (!global_irq_en |-> !tx_empty_irq && !tx_complete_irq)
        else $error("request without global enable");
    AST_LOW_BIT: assert property ($fell(serial_out_pin) |-> !serial_out_pin [*6])
        else $error("low bit too short");
    AST_DRIVE_LOW: assert property (!serial_out_pin |-> serial_out_oe)
        else $error("low level while pin released");
    AST_RELEASE: assert property ($fell(serial_out_oe) |-> serial_out_pin && $past(serial_out_pin))
        else $error("pin released mid frame");
    AST_IDLE_HIGH: assert property (!serial_out_oe |-> serial_out_pin)
        else $error("released line not idle high");
    AST_TXC_RISE: assert property ($rose(tx_complete_irq) |-> serial_out_pin)
        else $error("complete request outside idle");
    AST_ERR: assert property (acc |-> pslverr == !mapped)
        else $error("slave error wrong");
    AST_UNMAPPED_RD: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : usart_chk

bind usart_tx_rx_datapath usart_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .global_irq_en(global_irq_en), .tx_empty_irq(tx_empty_irq),
    .tx_complete_irq(tx_complete_irq), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .rx_pin_owned(rx_pin_owned));

// File: test/usart_peer.sv
`timescale 1ns/1ps
module usart_peer #(
    parameter int BIT_CLKS = 16
) (
    input wire logic pclk, // Clock
    input wire logic line_in, // Line from the block
    input wire logic [3:0] nbits, // Data bits expected
    input wire logic par_en, // Parity bit expected
    output logic line_out, // Line to the block
    output logic [10:0] got, // Last frame after start bit
    output int got_cnt // Frames seen
);
    logic [10:0] w;
    initial
    begin
        line_out = 1'b1;
        got = '0;
        got_cnt = 0;
    end
    // Mid-bit sampling once the start bit is confirmed
    always
    begin
        @(negedge line_in);
        repeat (BIT_CLKS / 2) @(posedge pclk);
        if (line_in === 1'b0)
        begin
            w = '0;
            for (int i = 0; i < nbits + par_en + 1; i++)
            begin
                repeat (BIT_CLKS) @(posedge pclk);
                w[i] = line_in;
            end
            got = w;
            got_cnt++;
        end
    end
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++)
        begin
            line_out <= f[i];
            repeat (BIT_CLKS) @(posedge pclk);
        end
        line_out <= 1'b1;
    endtask : send
endmodule : usart_peer

// File: test/usart_tx_rx_datapath_test.sv
`timescale 1ns/1ps
module usart_tx_rx_datapath_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic global_irq_en = 1'b0;
    logic tx_complete_ack = 1'b0;
    logic [31:0] prdata, r;
    logic pready, pslverr, tx_empty_irq, tx_complete_irq, serial_out_pin, serial_out_oe;
    logic rx_line, rx_pin_owned, tx_line, par_en = 1'b0;
    logic [3:0] nbits = 4'h8;
    logic [3:0] n;
    logic [10:0] got;
    logic [2:0] c;
    logic [8:0] d, e;
    logic [7:0] rxd[3];
    logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [7:0] offs[4] = '{8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rstv[4] = '{32'h0, 32'h6, 32'h0, 32'h0};
    int got_cnt, k, n_fail = 0, num_checks = 0, cyc = 0;
    assign tx_line = serial_out_oe ? serial_out_pin : 1'b1; // Pull-up when released
    always #2 pclk = ~pclk;
    usart_tx_rx_datapath DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en),
        .tx_complete_ack(tx_complete_ack), .tx_empty_irq(tx_empty_irq),
        .tx_complete_irq(tx_complete_irq), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .serial_in_pin(rx_line), .rx_pin_owned(rx_pin_owned),
        .sync_clock_in(1'b0), .sync_clock_out(), .sync_clock_oe());
    usart_peer u_peer (.pclk(pclk), .line_in(tx_line), .nbits(nbits), .par_en(par_en),
        .line_out(rx_line), .got(got), .got_cnt(got_cnt));
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        num_checks++;
        if (got_v !== exp_v)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] dat);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic cfg(input logic [2:0] cc, input logic pe, input logic od, input logic b8);
        nbits <= (cc == 3'h7) ? 4'h9 : {1'b0, cc} + 4'h5;
        par_en <= pe;
        xfer(usart_pkg::OFF_CONTROL_C, 1'b1, {26'h0, pe, od, 1'b0, cc[1:0], 1'b0});
        xfer(usart_pkg::OFF_CONTROL_B, 1'b1, {29'h3, cc[2], 1'b0, b8});
    endtask : cfg
    task automatic wait_got(input int want);
        int j;
        j = 0;
        while (got_cnt < want && j < 1000)
        begin
            @(posedge pclk);
            j++;
        end
    endtask : wait_got
    task automatic poll_txc();
        int j;
        j = 0;
        do
        begin
            xfer(usart_pkg::OFF_STATUS_A, 1'b0, 32'h0);
            j++;
        end
        while (r[6] !== 1'b1 && j < 50);
    endtask : poll_txc
    function automatic logic [31:0] expf(input logic [8:0] dv, input logic [3:0] nb,
        input logic pe, input logic od);
        logic [8:0] m;
        m = dv & ((9'h1 << nb) - 9'h1);
        expf = {23'h0, m} | (pe ? (({31'h0, ^m ^ od} << nb) | (32'h1 << (nb + 4'h1)))
            : (32'h1 << nb));
    endfunction : expf
    initial
    begin
        void'($urandom(32'h1fdf5856));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(usart_pkg::OFF_STATUS_A, 1'b0, 32'h0);
        chk(r, 32'h20);
        for (int i = 0; i < 4; i++)
        begin
            xfer(offs[i], 1'b0, 32'h0);
            chk(r, rstv[i]);
        end
        xfer(8'h14, 1'b1, $urandom);
        chk({31'h0, serial_out_oe}, 32'h0);
        for (int t = 0; t < 10; t++)
        begin
            c = codes[t % 5];
            n = (c == 3'h7) ? 4'h9 : {1'b0, c} + 4'h5;
            d = 9'($urandom);
            e = {d[8], 8'($urandom)};
            cfg(c, t[0], t[1], d[8]);
            k = got_cnt;
            xfer(usart_pkg::OFF_DATA, 1'b1, {24'($urandom), d[7:0]});
            xfer(usart_pkg::OFF_DATA, 1'b1, {24'($urandom), e[7:0]});
            xfer(usart_pkg::OFF_STATUS_A, 1'b0, 32'h0);
            chk(r, 32'h0);
            wait_got(k + 1);
            chk({21'h0, got}, expf(d, n, t[0], t[1]));
            wait_got(k + 2);
            chk({21'h0, got}, expf(e, n, t[0], t[1]));
            poll_txc();
            chk(r, 32'h60);
            xfer(usart_pkg::OFF_STATUS_A, 1'b1, 32'h40);
            xfer(usart_pkg::OFF_STATUS_A, 1'b0, 32'h0);
            chk(r, 32'h20);
        end
        // Double speed at half the tick rate keeps 16-clock bits
        xfer(usart_pkg::OFF_BAUD, 1'b1, 32'h1);
        xfer(usart_pkg::OFF_STATUS_A, 1'b1, 32'h2);
        cfg(3'h3, 1'b0, 1'b0, 1'b0);
        xfer(usart_pkg::OFF_CONTROL_B, 1'b1, 32'h78);
        global_irq_en <= 1'b1;
        @(negedge pclk);
        chk({30'h0, tx_empty_irq, tx_complete_irq}, 32'h2);
        d = 9'($urandom);
        k = got_cnt;
        xfer(usart_pkg::OFF_DATA, 1'b1, {23'h0, d});
        wait_got(k + 1);
        poll_txc();
        @(negedge pclk);
        chk({30'h0, tx_empty_irq, tx_complete_irq}, 32'h3);
        @(posedge pclk);
        global_irq_en <= 1'b0;
        @(negedge pclk);
        chk({30'h0, tx_empty_irq, tx_complete_irq}, 32'h0);
        @(posedge pclk);
        global_irq_en <= 1'b1;
        tx_complete_ack <= 1'b1;
        @(posedge pclk);
        tx_complete_ack <= 1'b0;
        @(negedge pclk);
        chk({30'h0, tx_empty_irq, tx_complete_irq}, 32'h2);
        global_irq_en <= 1'b0;
        k = got_cnt;
        xfer(usart_pkg::OFF_DATA, 1'b1, {23'h0, d});
        xfer(usart_pkg::OFF_CONTROL_B, 1'b1, 32'h10);
        wait_got(k + 1);
        chk({21'h0, got}, expf(d, 4'h8, 1'b0, 1'b0));
        for (int j = 0; j < 100 && serial_out_oe !== 1'b0; j++)
            @(posedge pclk);
        chk({31'h0, serial_out_oe}, 32'h0);
        xfer(usart_pkg::OFF_STATUS_A, 1'b1, 32'h0);
        xfer(usart_pkg::OFF_BAUD, 1'b1, 32'h0);
        cfg(3'h3, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            rxd[i] = 8'($urandom);
            @(posedge pclk);
            u_peer.send({3'b111, rxd[i], 1'b0}, 10);
        end
        xfer(usart_pkg::OFF_STATUS_A, 1'b0, 32'h0);
        chk(r, 32'he0);
        xfer(usart_pkg::OFF_DATA, 1'b0, 32'h0);
        chk(r, {24'h0, rxd[0]});
        xfer(usart_pkg::OFF_DATA, 1'b0, 32'h0);
        chk(r, {24'h0, rxd[1]});
        xfer(usart_pkg::OFF_STATUS_A, 1'b0, 32'h0);
        chk(r, 32'h60);
        cfg(3'h7, 1'b1, 1'b0, 1'b0);
        d = 9'($urandom);
        @(posedge pclk);
        u_peer.send({1'b1, ^d, d, 1'b0}, 12);
        xfer(usart_pkg::OFF_CONTROL_B, 1'b0, 32'h0);
        chk({31'h0, r[1]}, {31'h0, d[8]});
        xfer(usart_pkg::OFF_DATA, 1'b0, 32'h0);
        chk(r, {24'h0, d[7:0]});
        cfg(3'h0, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge pclk);
            u_peer.send({1'b1, d[4:0], 1'b0}, 7);
        end
        xfer(usart_pkg::OFF_DATA, 1'b0, 32'h0);
        chk(r, {27'h0, d[4:0]});
        xfer(usart_pkg::OFF_CONTROL_B, 1'b1, 32'h08);
        xfer(usart_pkg::OFF_CONTROL_B, 1'b1, 32'h18);
        xfer(usart_pkg::OFF_STATUS_A, 1'b0, 32'h0);
        chk(r, 32'h60);
        summarize();
    end
endmodule : usart_tx_rx_datapath_test
